// >>> gesa_pkg.sv
// constants, types and field layout of the exception status aggregator
// Function
// - state code tracks current supervisor state
// - summary bit 7 always reads one
// - summary bits: alarms 0-2, warnings 4-6
// - summary flag is OR of group bytes
// - detail bit one while condition present
// - unsupported detail bits always read zero
// - alarm and warning common and maker bitmaps share bit positions
// - each group gives size then bytes
// - common group size two, two bytes
// - common memory and supply fault bit positions
// - unassigned common bits read zero
// - device alarm group size reads six
// - device alarm diaphragm and electronics bits
// - maker alarm size one, serial bit 0
// - enables default on, off clears bits
// - device warning group size seven, layout
package gesa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // supervisor states
  typedef enum logic [2:0] {
    GESA_UNDEFINED     = 3'h0,
    GESA_SELF_TESTING  = 3'h1,
    GESA_IDLE          = 3'h2,
    GESA_SELF_TEST_EXC = 3'h3,
    GESA_EXECUTING     = 3'h4,
    GESA_ABORT         = 3'h5,
    GESA_CRITICAL      = 3'h6
  } gesa_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // summary byte field positions
  localparam int GESA_SUM_ALM_COMMON  = 0;
  localparam int GESA_SUM_ALM_DEVICE  = 1;
  localparam int GESA_SUM_ALM_MAKER   = 2;
  localparam int GESA_SUM_RESERVED    = 3;
  localparam int GESA_SUM_WRN_COMMON  = 4;
  localparam int GESA_SUM_WRN_DEVICE  = 5;
  localparam int GESA_SUM_WRN_MAKER   = 6;
  localparam int GESA_SUM_EXPANDED    = 7;

  // group sizes
  localparam logic [7:0] GESA_COMMON_SIZE     = 8'h02;
  localparam logic [7:0] GESA_DEV_ALARM_SIZE  = 8'h06;
  localparam logic [7:0] GESA_DEV_WARN_SIZE   = 8'h07;
  localparam logic [7:0] GESA_MAKER_SIZE      = 8'h01;
  localparam int         GESA_COMMON_BYTES    = 2;
  localparam int         GESA_DEV_ALARM_BYTES = 6;
  localparam int         GESA_DEV_WARN_BYTES  = 7;

  // common detail bit positions
  localparam int GESA_BIT_CODE_MEM  = 2;
  localparam int GESA_BIT_NV_MEM    = 3;
  localparam int GESA_BIT_DATA_MEM  = 4;
  localparam int GESA_BIT_SUPPLY    = 3;

  // device and maker detail bit positions
  localparam int GESA_BIT_DIAPHRAGM   = 0;
  localparam int GESA_BIT_ELECTRONICS = 1;
  localparam int GESA_BIT_READ_INVAL  = 0;
  localparam int GESA_BIT_OVERRANGE   = 1;
  localparam int GESA_BIT_UNDERRANGE  = 2;
  localparam int GESA_BIT_DEGAS_HIGH  = 3;
  localparam int GESA_BIT_SERIAL      = 0;

  // reset values
  localparam logic [7:0] GESA_BYTE_RESET   = 8'h00;
  localparam logic       GESA_ENABLE_RESET = 1'b1;
  localparam logic [7:0] GESA_SUM_RESET    = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // condition inputs
  typedef struct packed {
    logic code_memory_fault;
    logic nonvolatile_memory_fault;
    logic data_memory_fault;
    logic supply_input_fault;
  } gesa_common_cond_t;

  typedef struct packed {
    gesa_common_cond_t common;
    logic              diaphragm_failure;
    logic [2:0]        electronics_failure;
    logic              serial_comm_alarm;
  } gesa_alarm_cond_t;

  typedef struct packed {
    gesa_common_cond_t common;
    logic              reading_valid;
    logic              overrange;
    logic              underrange;
    logic [1:0]        electronics_warning;
    logic              degas_pressure_high;
    logic              serial_comm_warning;
  } gesa_warning_cond_t;

  // reported detail attributes
  typedef struct packed {
    logic [7:0]                           common_size;
    logic [7:0]                           common_detail_byte0;
    logic [7:0]                           common_detail_byte1;
    logic [7:0]                           device_size;
    logic [GESA_DEV_ALARM_BYTES-1:0][7:0] device_detail;
    logic [7:0]                           maker_size;
    logic [7:0]                           maker_alarm_detail;
  } gesa_alarm_report_t;

  typedef struct packed {
    logic [7:0]                          common_size;
    logic [7:0]                          common_detail_byte0;
    logic [7:0]                          common_detail_byte1;
    logic [7:0]                          device_size;
    logic [GESA_DEV_WARN_BYTES-1:0][7:0] device_detail;
    logic [7:0]                          maker_size;
    logic [7:0]                          maker_warning_detail;
  } gesa_warning_report_t;

  // supervisor requests
  typedef struct packed {
    logic self_test_pass;
    logic self_test_fail;
    logic start;
    logic stop;
    logic abort;
    logic recover;
    logic reset;
    logic critical_fault;
  } gesa_req_t;

endpackage : gesa_pkg

// >>> gesa_or_reduce.sv
// or-reduction of one detail group into a summary flag
module gesa_or_reduce #(
  parameter int NBYTES = 1
) (
  input  wire logic [NBYTES-1:0][7:0] detail,
  output wire logic                   flag
);

  assign flag = |detail;

endmodule : gesa_or_reduce

// >>> gesa_aggregator.sv
// supervisor state code and exception status aggregation
module gesa_aggregator (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire gesa_pkg::gesa_req_t           req,
  input  wire gesa_pkg::gesa_alarm_cond_t    alarm_cond,
  input  wire gesa_pkg::gesa_warning_cond_t  warning_cond,
  input  wire logic                          alarm_enable_wr,
  input  wire logic                          warning_enable_wr,
  input  wire logic                          enable_wdata,
  output gesa_pkg::gesa_state_t              state,
  output logic [7:0]                         supervisor_state_code,
  output logic [7:0]                         exception_summary,
  output gesa_pkg::gesa_alarm_report_t       alarm_report,
  output gesa_pkg::gesa_warning_report_t     warning_report,
  output logic                               alarm_enable,
  output logic                               warning_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // condition qualified by its enable
  function automatic logic gate(input logic en, input logic cond);
    gate = en & cond;
  endfunction : gate

  // one detail byte with a single supported bit
  function automatic logic [7:0] one_bit(input int pos, input logic val);
    logic [7:0] b;
    b      = 8'h00;
    b[pos] = val;
    one_bit = b;
  endfunction : one_bit

  // supervisor state as the eight-bit code that the master reads
  function automatic logic [7:0] state_code(input gesa_pkg::gesa_state_t s);
    state_code = {5'h00, s};
  endfunction : state_code

  ////////////////////////////////////////////////////////////////////////////
  // supervisor state machine

  gesa_pkg::gesa_state_t next_state;
  logic [7:0]            next_supervisor_state_code;

  always_comb begin
    next_state = state;
    unique case (state)
      gesa_pkg::GESA_UNDEFINED: begin
        next_state = gesa_pkg::GESA_SELF_TESTING;
      end
      gesa_pkg::GESA_SELF_TESTING: begin
        if (req.self_test_fail) begin
          next_state = gesa_pkg::GESA_SELF_TEST_EXC;
        end else if (req.self_test_pass) begin
          next_state = gesa_pkg::GESA_IDLE;
        end
      end
      gesa_pkg::GESA_IDLE: begin
        if (req.abort) begin
          next_state = gesa_pkg::GESA_ABORT;
        end else if (req.start) begin
          next_state = gesa_pkg::GESA_EXECUTING;
        end
      end
      gesa_pkg::GESA_SELF_TEST_EXC: begin
        // only a reset request or a critical fault leaves the exception state
        next_state = gesa_pkg::GESA_SELF_TEST_EXC;
      end
      gesa_pkg::GESA_EXECUTING: begin
        if (req.abort) begin
          next_state = gesa_pkg::GESA_ABORT;
        end else if (req.stop) begin
          next_state = gesa_pkg::GESA_IDLE;
        end
      end
      gesa_pkg::GESA_ABORT: begin
        if (req.recover) begin
          next_state = gesa_pkg::GESA_IDLE;
        end
      end
      gesa_pkg::GESA_CRITICAL: begin
        // no request leaves critical fault
        next_state = gesa_pkg::GESA_CRITICAL;
      end
      default: begin
        next_state = gesa_pkg::GESA_UNDEFINED;
      end
    endcase
    // reset restarts self test from every state but critical fault
    if (req.reset && state != gesa_pkg::GESA_CRITICAL) begin
      next_state = gesa_pkg::GESA_SELF_TESTING;
    end
    // a critical fault overrides every other request, reset included
    if (req.critical_fault) begin
      next_state = gesa_pkg::GESA_CRITICAL;
    end
    next_supervisor_state_code = supervisor_state_code;
    if (next_state != state) begin
      next_supervisor_state_code = state_code(next_state);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state                 <= gesa_pkg::GESA_SELF_TESTING;
      supervisor_state_code <= state_code(gesa_pkg::GESA_SELF_TESTING);
    end else begin
      state                 <= next_state;
      supervisor_state_code <= next_supervisor_state_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm and warning enables
  // a write takes effect at the edge, the gated details one edge later

  logic next_alarm_enable;
  logic next_warning_enable;

  always_comb begin
    next_alarm_enable   = alarm_enable;
    next_warning_enable = warning_enable;
    if (alarm_enable_wr) begin
      next_alarm_enable = enable_wdata;
    end
    if (warning_enable_wr) begin
      next_warning_enable = enable_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alarm_enable   <= gesa_pkg::GESA_ENABLE_RESET;
      warning_enable <= gesa_pkg::GESA_ENABLE_RESET;
    end else begin
      alarm_enable   <= next_alarm_enable;
      warning_enable <= next_warning_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detail assembly, live every cycle, no latching

  gesa_pkg::gesa_alarm_report_t   next_alarm_report;
  gesa_pkg::gesa_warning_report_t next_warning_report;
  logic                           ae;
  logic                           we;

  assign ae = alarm_enable;
  assign we = warning_enable;

  always_comb begin
    next_alarm_report = '0;
    // sizes stay visible while the group is disabled
    next_alarm_report.common_size = gesa_pkg::GESA_COMMON_SIZE;
    next_alarm_report.common_detail_byte0[gesa_pkg::GESA_BIT_CODE_MEM] =
      gate(ae, alarm_cond.common.code_memory_fault);
    next_alarm_report.common_detail_byte0[gesa_pkg::GESA_BIT_NV_MEM] =
      gate(ae, alarm_cond.common.nonvolatile_memory_fault);
    next_alarm_report.common_detail_byte0[gesa_pkg::GESA_BIT_DATA_MEM] =
      gate(ae, alarm_cond.common.data_memory_fault);
    next_alarm_report.common_detail_byte1[gesa_pkg::GESA_BIT_SUPPLY] =
      gate(ae, alarm_cond.common.supply_input_fault);
    next_alarm_report.device_size = gesa_pkg::GESA_DEV_ALARM_SIZE;
    next_alarm_report.device_detail[0] = one_bit(
      gesa_pkg::GESA_BIT_DIAPHRAGM,
      gate(ae, alarm_cond.diaphragm_failure));
    // electronics failure sits in the second byte of each sensor pair
    for (int s = 0; s < 3; s++) begin
      next_alarm_report.device_detail[2*s+1] = one_bit(
        gesa_pkg::GESA_BIT_ELECTRONICS,
        gate(ae, alarm_cond.electronics_failure[s]));
    end
    next_alarm_report.maker_size = gesa_pkg::GESA_MAKER_SIZE;
    next_alarm_report.maker_alarm_detail = one_bit(
      gesa_pkg::GESA_BIT_SERIAL,
      gate(ae, alarm_cond.serial_comm_alarm));
  end

  always_comb begin
    next_warning_report = '0;
    // sizes stay visible while the group is disabled
    next_warning_report.common_size = gesa_pkg::GESA_COMMON_SIZE;
    // common bits sit at the same places as for alarms
    next_warning_report.common_detail_byte0[gesa_pkg::GESA_BIT_CODE_MEM] =
      gate(we, warning_cond.common.code_memory_fault);
    next_warning_report.common_detail_byte0[gesa_pkg::GESA_BIT_NV_MEM] =
      gate(we, warning_cond.common.nonvolatile_memory_fault);
    next_warning_report.common_detail_byte0[gesa_pkg::GESA_BIT_DATA_MEM] =
      gate(we, warning_cond.common.data_memory_fault);
    next_warning_report.common_detail_byte1[gesa_pkg::GESA_BIT_SUPPLY] =
      gate(we, warning_cond.common.supply_input_fault);
    next_warning_report.device_size = gesa_pkg::GESA_DEV_WARN_SIZE;
    next_warning_report.device_detail[0][gesa_pkg::GESA_BIT_READ_INVAL] =
      gate(we, ~warning_cond.reading_valid);
    next_warning_report.device_detail[0][gesa_pkg::GESA_BIT_OVERRANGE] =
      gate(we, warning_cond.overrange);
    next_warning_report.device_detail[0][gesa_pkg::GESA_BIT_UNDERRANGE] =
      gate(we, warning_cond.underrange);
    for (int s = 0; s < 2; s++) begin
      next_warning_report.device_detail[2*s+2] = one_bit(
        gesa_pkg::GESA_BIT_ELECTRONICS,
        gate(we, warning_cond.electronics_warning[s]));
    end
    next_warning_report.device_detail[6] = one_bit(
      gesa_pkg::GESA_BIT_DEGAS_HIGH,
      gate(we, warning_cond.degas_pressure_high));
    next_warning_report.maker_size = gesa_pkg::GESA_MAKER_SIZE;
    next_warning_report.maker_warning_detail = one_bit(
      gesa_pkg::GESA_BIT_SERIAL,
      gate(we, warning_cond.serial_comm_warning));
  end

  ////////////////////////////////////////////////////////////////////////////
  // group summaries

  logic alm_common_flag;
  logic alm_device_flag;
  logic alm_maker_flag;
  logic wrn_common_flag;
  logic wrn_device_flag;
  logic wrn_maker_flag;

  gesa_or_reduce #(
    .NBYTES (gesa_pkg::GESA_COMMON_BYTES)
  ) u_alm_common (
    .detail ({next_alarm_report.common_detail_byte1,
              next_alarm_report.common_detail_byte0}),
    .flag   (alm_common_flag)
  );

  gesa_or_reduce #(
    .NBYTES (gesa_pkg::GESA_DEV_ALARM_BYTES)
  ) u_alm_device (
    .detail (next_alarm_report.device_detail),
    .flag   (alm_device_flag)
  );

  gesa_or_reduce #(
    .NBYTES (1)
  ) u_alm_maker (
    .detail (next_alarm_report.maker_alarm_detail),
    .flag   (alm_maker_flag)
  );

  gesa_or_reduce #(
    .NBYTES (gesa_pkg::GESA_COMMON_BYTES)
  ) u_wrn_common (
    .detail ({next_warning_report.common_detail_byte1,
              next_warning_report.common_detail_byte0}),
    .flag   (wrn_common_flag)
  );

  gesa_or_reduce #(
    .NBYTES (gesa_pkg::GESA_DEV_WARN_BYTES)
  ) u_wrn_device (
    .detail (next_warning_report.device_detail),
    .flag   (wrn_device_flag)
  );

  gesa_or_reduce #(
    .NBYTES (1)
  ) u_wrn_maker (
    .detail (next_warning_report.maker_warning_detail),
    .flag   (wrn_maker_flag)
  );

  // flags come from the next details so summary and details turn together
  logic [7:0] next_exception_summary;

  always_comb begin
    next_exception_summary = 8'h00;
    next_exception_summary[gesa_pkg::GESA_SUM_ALM_COMMON] =
      alm_common_flag;
    next_exception_summary[gesa_pkg::GESA_SUM_ALM_DEVICE] =
      alm_device_flag;
    next_exception_summary[gesa_pkg::GESA_SUM_ALM_MAKER] =
      alm_maker_flag;
    next_exception_summary[gesa_pkg::GESA_SUM_RESERVED] = 1'b0;
    next_exception_summary[gesa_pkg::GESA_SUM_WRN_COMMON] =
      wrn_common_flag;
    next_exception_summary[gesa_pkg::GESA_SUM_WRN_DEVICE] =
      wrn_device_flag;
    next_exception_summary[gesa_pkg::GESA_SUM_WRN_MAKER] =
      wrn_maker_flag;
    next_exception_summary[gesa_pkg::GESA_SUM_EXPANDED] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // report registers, refreshed every cycle
  // reports clear under reset, sizes included, summary keeps its top bit

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alarm_report      <= '0;
      warning_report    <= '0;
      exception_summary <= gesa_pkg::GESA_SUM_RESET;
    end else begin
      alarm_report      <= next_alarm_report;
      warning_report    <= next_warning_report;
      exception_summary <= next_exception_summary;
    end
  end

endmodule : gesa_aggregator

// >>> gesa_assertions.sv
// concurrent checks on the ports of the exception status aggregator
module gesa_chk (
  input wire logic                         clock,
  input wire logic                         rst_n,
  input wire gesa_pkg::gesa_req_t          req,
  input wire gesa_pkg::gesa_alarm_cond_t   alarm_cond,
  input wire gesa_pkg::gesa_warning_cond_t warning_cond,
  input wire logic                         alarm_enable_wr,
  input wire logic                         warning_enable_wr,
  input wire logic                         enable_wdata,
  input wire gesa_pkg::gesa_state_t        state,
  input wire logic [7:0]                   supervisor_state_code,
  input wire logic [7:0]                   exception_summary,
  input wire gesa_pkg::gesa_alarm_report_t alarm_report,
  input wire gesa_pkg::gesa_warning_report_t warning_report,
  input wire logic                         alarm_enable,
  input wire logic                         warning_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] grp_or;
  logic       rsvd_zero;
  logic [7:0] wr_any;

  ////////////////////////////////////////
  assign grp_or = {|warning_report.maker_warning_detail,
                   |warning_report.device_detail,
                   |{warning_report.common_detail_byte0,
                     warning_report.common_detail_byte1},
                   1'b0, |alarm_report.maker_alarm_detail,
                   |alarm_report.device_detail,
                   |{alarm_report.common_detail_byte0,
                     alarm_report.common_detail_byte1}};
  assign rsvd_zero = ((alarm_report.common_detail_byte0 & 8'he3) == 8'h00)
    && ((alarm_report.common_detail_byte1 & 8'hf7) == 8'h00)
    && (alarm_report.device_detail[2] == 8'h00)
    && (alarm_report.device_detail[4] == 8'h00)
    && ((alarm_report.maker_alarm_detail & 8'hfe) == 8'h00);
  assign wr_any = warning_report.common_detail_byte0
    | warning_report.common_detail_byte1
    | warning_report.maker_warning_detail;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////
  property p_code;
    supervisor_state_code == {5'h00, state};
  endproperty
  a_code: assert property (p_code)
    else $error("state code differs from state");
  property p_crit;
    req.critical_fault |=> state == gesa_pkg::GESA_CRITICAL;
  endproperty
  a_crit: assert property (p_crit)
    else $error("critical fault not entered");
  property p_exc;
    state == gesa_pkg::GESA_SELF_TESTING && req.self_test_fail
      && !req.critical_fault && !req.reset
      |=> state == gesa_pkg::GESA_SELF_TEST_EXC;
  endproperty
  a_exc: assert property (p_exc)
    else $error("self-test failure not reported");
  property p_fixed;
    exception_summary[7] && !exception_summary[3];
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("summary fixed bits wrong");
  property p_or;
    exception_summary[6:0] == grp_or;
  endproperty
  a_or: assert property (p_or)
    else $error("summary flag is not the group or");
  property p_sizes;
    $past(rst_n) |-> {alarm_report.common_size, alarm_report.device_size,
      alarm_report.maker_size, warning_report.common_size,
      warning_report.device_size, warning_report.maker_size}
      == 48'h0206_0102_0701;
  endproperty
  a_sizes: assert property (p_sizes)
    else $error("group size wrong");
  property p_diaph;
    $past(rst_n) |-> alarm_report.device_detail[0] == {7'h00,
      $past(alarm_cond.diaphragm_failure) & $past(alarm_enable)};
  endproperty
  a_diaph: assert property (p_diaph)
    else $error("diaphragm alarm byte wrong");
  property p_invalid;
    $past(rst_n) |-> warning_report.device_detail[0][0] ==
      (!$past(warning_cond.reading_valid) & $past(warning_enable));
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("reading invalid bit wrong");
  property p_rsvd;
    rsvd_zero;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("unsupported alarm bit set");
  property p_en_wr;
    alarm_enable_wr |=> alarm_enable == $past(enable_wdata);
  endproperty
  a_en_wr: assert property (p_en_wr)
    else $error("alarm enable not loaded");
  property p_dis;
    $past(rst_n) && !$past(warning_enable)
      |-> wr_any == 8'h00 && warning_report.device_detail == '0;
  endproperty
  a_dis: assert property (p_dis)
    else $error("disabled warning bit set");

  c_exec: cover property (state == gesa_pkg::GESA_EXECUTING);
  c_full: cover property (exception_summary == 8'hf7);
  c_off: cover property (alarm_enable_wr && !enable_wdata);
endmodule : gesa_chk

bind gesa_aggregator gesa_chk i_gesa_chk (.clock, .rst_n, .req,
  .alarm_cond, .warning_cond, .alarm_enable_wr, .warning_enable_wr,
  .enable_wdata, .state, .supervisor_state_code, .exception_summary,
  .alarm_report, .warning_report, .alarm_enable, .warning_enable);

// >>> gesa_master_model.sv
// fieldbus master model that recovers a self-test exception
module gesa_master_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       recover_en,
  input  wire logic [7:0] supervisor_state_code,
  output logic            reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic next_reset_req;

  ////////////////////////////////////////
  // one reset request per sighting of the exception code
  always_comb begin
    next_reset_req = recover_en && supervisor_state_code == 8'h03
                     && !reset_req;
  end
  always_ff @(posedge clock) begin
    reset_req <= rst_n ? next_reset_req : 1'b0;
  end
endmodule : gesa_master_model

// >>> tb_top.sv
// self-checking testbench for the exception status aggregator
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] tb_req = 8'h00;
  logic rec_en = 1'b0;
  logic m_reset;
  gesa_pkg::gesa_req_t req;
  gesa_pkg::gesa_alarm_cond_t alarm_cond = '0;
  gesa_pkg::gesa_warning_cond_t warning_cond = 11'h040;
  logic alarm_enable_wr = 1'b0;
  logic warning_enable_wr = 1'b0;
  logic enable_wdata = 1'b0;
  gesa_pkg::gesa_state_t state;
  logic [7:0] supervisor_state_code;
  logic [7:0] exception_summary;
  gesa_pkg::gesa_alarm_report_t alarm_report;
  gesa_pkg::gesa_warning_report_t warning_report;
  logic alarm_enable;
  logic warning_enable;
  logic a_en = 1'b1;
  logic w_en = 1'b1;
  int err_total = 0;
  int samples_checked = 0;
  // request in the high byte, expected state code in the low byte
  logic [15:0] seq [13] = '{16'h8002, 16'h2004, 16'h1002, 16'h0402,
    16'h2004, 16'h0805, 16'h2005, 16'h0402, 16'h0805, 16'h0201,
    16'h0106, 16'h0206, 16'h8006};

  assign req = gesa_pkg::gesa_req_t'(tb_req | {6'h00, m_reset, 1'b0});
  always #20 clock = ~clock;

  gesa_aggregator i_gesa_aggregator (.clock, .rst_n, .req, .alarm_cond,
    .warning_cond, .alarm_enable_wr, .warning_enable_wr, .enable_wdata,
    .state, .supervisor_state_code, .exception_summary, .alarm_report,
    .warning_report, .alarm_enable, .warning_enable);
  gesa_master_model i_gesa_master_model (.clock, .rst_n,
    .recover_en(rec_en), .supervisor_state_code, .reset_req(m_reset));

  ////////////////////////////////////////
  task automatic check(input logic [103:0] seen, input logic [103:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic do_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    a_en = 1'b1;
    w_en = 1'b1;
    check(supervisor_state_code, 8'h01);
    check(exception_summary, 8'h80);
    check({alarm_enable, warning_enable}, 2'b11);
  endtask : do_reset

  task automatic req_step(input logic [7:0] r, input logic [7:0] e);
    @(posedge clock);
    tb_req <= r;
    @(posedge clock);
    tb_req <= 8'h00;
    #1;
    check(supervisor_state_code, e);
  endtask : req_step

  task automatic en_wr(input logic sel, input logic v);
    @(posedge clock);
    alarm_enable_wr <= sel;
    warning_enable_wr <= !sel;
    enable_wdata <= v;
    @(posedge clock);
    alarm_enable_wr <= 1'b0;
    warning_enable_wr <= 1'b0;
    if (sel) begin
      a_en = v;
    end else begin
      w_en = v;
    end
    #1;
    check(sel ? alarm_enable : warning_enable, v);
  endtask : en_wr

  function automatic gesa_pkg::gesa_alarm_report_t exp_a(
      input logic [8:0] c, input logic en);
    gesa_pkg::gesa_alarm_report_t r;
    r = '0;
    r.common_size = 8'h02;
    r.device_size = 8'h06;
    r.maker_size = 8'h01;
    if (en) begin
      r.common_detail_byte0 = {3'h0, c[6], c[7], c[8], 2'h0};
      r.common_detail_byte1 = {4'h0, c[5], 3'h0};
      r.device_detail[0] = {7'h00, c[4]};
      r.device_detail[1] = {6'h00, c[1], 1'b0};
      r.device_detail[3] = {6'h00, c[2], 1'b0};
      r.device_detail[5] = {6'h00, c[3], 1'b0};
      r.maker_alarm_detail = {7'h00, c[0]};
    end
    return r;
  endfunction : exp_a

  function automatic gesa_pkg::gesa_warning_report_t exp_w(
      input logic [10:0] w, input logic en);
    gesa_pkg::gesa_warning_report_t r;
    r = '0;
    r.common_size = 8'h02;
    r.device_size = 8'h07;
    r.maker_size = 8'h01;
    if (en) begin
      r.common_detail_byte0 = {3'h0, w[8], w[9], w[10], 2'h0};
      r.common_detail_byte1 = {4'h0, w[7], 3'h0};
      r.device_detail[0] = {5'h00, w[4], w[5], !w[6]};
      r.device_detail[2] = {6'h00, w[2], 1'b0};
      r.device_detail[4] = {6'h00, w[3], 1'b0};
      r.device_detail[6] = {4'h0, w[1], 3'h0};
      r.maker_warning_detail = {7'h00, w[0]};
    end
    return r;
  endfunction : exp_w

  task automatic cond_chk(input logic [8:0] a, input logic [10:0] w);
    gesa_pkg::gesa_alarm_report_t ea;
    gesa_pkg::gesa_warning_report_t ew;
    @(posedge clock);
    alarm_cond <= a;
    warning_cond <= w;
    @(posedge clock);
    #1;
    ea = exp_a(a, a_en);
    ew = exp_w(w, w_en);
    check(alarm_report, ea);
    check(warning_report, ew);
    check(exception_summary, {1'b1, |ew.maker_warning_detail,
      |ew.device_detail, |{ew.common_detail_byte0, ew.common_detail_byte1},
      1'b0, |ea.maker_alarm_detail, |ea.device_detail,
      |{ea.common_detail_byte0, ea.common_detail_byte1}});
  endtask : cond_chk

  ////////////////////////////////////////
  initial begin
    do_reset();
    foreach (seq[i]) req_step(seq[i][15:8], seq[i][7:0]);
    @(posedge clock);
    tb_req <= 8'h00;
    do_reset();
    req_step(8'hc0, 8'h03);
    req_step(8'h20, 8'h03);
    @(posedge clock);
    tb_req <= 8'h00;
    rec_en <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      @(posedge clock);
      #1;
      if (supervisor_state_code === 8'h01) break;
    end
    check(supervisor_state_code, 8'h01);
    @(posedge clock);
    rec_en <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      cond_chk(9'h001 << i, (11'h001 << i) ^ 11'h040);
    end
    cond_chk(9'h1ff, 11'h7bf);
    en_wr(1'b1, 1'b0);
    en_wr(1'b0, 1'b0);
    cond_chk(9'h1ff, 11'h7bf);
    en_wr(1'b1, 1'b1);
    cond_chk(9'h1ff, 11'h7bf);
    en_wr(1'b0, 1'b1);
    cond_chk(9'h1ff, 11'h7bf);
    cond_chk(9'h000, 11'h040);
    close_out();
  end

  initial begin
    repeat (4000) @(posedge clock);
    err_total++;
    close_out();
  end
endmodule : tb_top
